//--- logic/epe_pkg.sv
// Shared constants and types of the EEPROM program/erase control block
package epe_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int NVM_DEPTH = 256;
    localparam int CNT_W = 16;

    // CPU address map
    localparam logic [15:0] CTRL_ADDR = 16'h001c;
    localparam logic [15:0] STAT_ADDR = 16'h001d;
    localparam logic [15:0] ARRAY_FIRST = 16'h0400;
    localparam logic [15:0] ARRAY_LAST = 16'h04ff;

    // Control register bit positions
    localparam int BIT_PUMP = 6;
    localparam int BIT_ER_HIGH = 4;
    localparam int BIT_ER_LOW = 3;
    localparam int BIT_CAPTURE = 2;
    localparam int BIT_OSC = 1;
    localparam int BIT_POWER = 0;

    // Status register bit positions
    localparam int ST_BIT_ARMED = 0;
    localparam int ST_BIT_PULSE = 1;
    localparam int ST_BIT_DONE = 2;
    localparam int ST_BIT_OSC_READY = 3;
    localparam int ST_BIT_FALLEN = 4;

    // Data values
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] BLOCKED_READ = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [5:0] BLOCK_FIRST = 6'h00;
    localparam logic [5:0] BLOCK_LAST = 6'h3f;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // Operation selected by the two erase-select bits, in code order 0..3
    typedef enum logic [1:0] {
        MODE_PROGRAM,
        MODE_BYTE_ERASE,
        MODE_BLOCK_ERASE,
        MODE_BULK_ERASE
    } epe_mode_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_PULSE,
        ST_DONE
    } epe_state_t;

    // Software-visible control bits
    typedef struct packed {
        logic pump;
        logic erHigh;
        logic erLow;
        logic capture;
        logic oscSel;
        logic power;
    } epe_ctrl_t;

    // Captured programming target
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } epe_capture_t;
endpackage : epe_pkg

//--- logic/epe_nvm_control.sv
// EEPROM array with its program/erase control register and pulse sequencer
//
// Contract
// - Array spans 0x0400-0x04FF; all program/erase control sits in one register.
// - Erased bytes read 0xFF; programming only clears bits written as zero.
// - Charge pump enable bit is read/write and cleared by reset.
// - Programming voltage reaches the array only while program power is set.
// - Two erase-select bits choose program, byte, block or bulk erase; reset zero.
// - Byte erase clears only the addressed byte to ones.
// - Block erase clears the aligned 64-byte block holding the address.
// - Bulk erase clears all 256 bytes whatever address was written.
// - With capture set, array writes latch address and data instead; the code ignores array writes while the pulse runs.
// - Array reads are blocked once capture is set and a write latched.
// - Oscillator select chooses RC oscillator or CPU clock for array timing.
// - Program power turns pump on and powers the array for internal pulse.
// - Program power can be set only while capture is one; reset clears.
// - Indexed reads with base inside array range may return wrong data; the code returns the stored byte and raises busRdUnreliable instead.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module epe_nvm_control #(
    parameter logic [15:0] BYTE_PROGRAM_CYCLES = 16'h0064,
    parameter logic [15:0] BYTE_ERASE_CYCLES = 16'h0064,
    parameter logic [15:0] BLOCK_ERASE_CYCLES = 16'h0064,
    parameter logic [15:0] BULK_ERASE_CYCLES = 16'h0064,
    parameter logic [15:0] OSC_SETTLE_CYCLES = 16'h0020,
    parameter logic [15:0] VOLTAGE_FALL_CYCLES = 16'h0020
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    input wire logic busRdIndexed,
    input wire logic [15:0] busRdBase,
    output logic [7:0] busRdata,
    output logic busRdUnreliable,
    input wire logic rcOscTick,
    output logic pumpOn,
    output logic arrayHvOn
);
    epe_pkg::epe_ctrl_t ctrl_q;
    epe_pkg::epe_capture_t cap_q;
    epe_pkg::epe_state_t state_q;
    epe_pkg::epe_mode_t mode;
    logic [7:0] mem [epe_pkg::NVM_DEPTH];
    logic [7:0] rdata_q;
    logic unreliable_q;
    logic [15:0] pulseCnt_q;
    logic [15:0] settleCnt_q;
    logic [15:0] fallCnt_q;
    logic [15:0] pulseTarget;
    logic rcSync1_q;
    logic rcSync2_q;
    logic rcSync3_q;
    logic rcEdge;
    logic arrayTick;
    logic wrCtrl;
    logic wrArray;
    logic rdArray;
    logic inArray;
    logic baseInArray;
    logic armed;
    logic readBlocked;
    logic commit;
    logic oscReady;
    logic fallen;
    logic [7:0] statusByte;
    logic [7:0] ctrlByte;

    // Address decode
    assign inArray = busAddr >= epe_pkg::ARRAY_FIRST && busAddr <= epe_pkg::ARRAY_LAST;
    assign baseInArray = busRdBase >= epe_pkg::ARRAY_FIRST
        && busRdBase <= epe_pkg::ARRAY_LAST;
    assign wrCtrl = busWr && busAddr == epe_pkg::CTRL_ADDR;
    assign wrArray = busWr && inArray;
    assign rdArray = busRd && inArray;
    assign mode = epe_pkg::epe_mode_t'({ctrl_q.erHigh, ctrl_q.erLow});
    assign armed = state_q != epe_pkg::ST_IDLE;
    assign readBlocked = ctrl_q.capture && armed;

    // RC oscillator tick arrives from another domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rcSync1_q <= 1'b0;
            rcSync2_q <= 1'b0;
            rcSync3_q <= 1'b0;
        end else begin
            rcSync1_q <= rcOscTick;
            rcSync2_q <= rcSync1_q;
            rcSync3_q <= rcSync2_q;
        end
    end
    assign rcEdge = rcSync2_q && !rcSync3_q;

    // Array timebase: RC edges or every CPU clock
    assign arrayTick = ctrl_q.oscSel ? rcEdge : 1'b1;

    // Control register; power bit refuses to rise unless capture already set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
        end else if (wrCtrl) begin
            ctrl_q.pump <= busWdata[epe_pkg::BIT_PUMP];
            ctrl_q.erHigh <= busWdata[epe_pkg::BIT_ER_HIGH];
            ctrl_q.erLow <= busWdata[epe_pkg::BIT_ER_LOW];
            ctrl_q.capture <= busWdata[epe_pkg::BIT_CAPTURE];
            ctrl_q.oscSel <= busWdata[epe_pkg::BIT_OSC];
            if (!busWdata[epe_pkg::BIT_POWER]) begin
                ctrl_q.power <= 1'b0;
            end else if (ctrl_q.capture) begin
                ctrl_q.power <= 1'b1;
            end
        end
    end

    // Pump runs for either bit; high voltage only with power
    assign pumpOn = ctrl_q.pump || ctrl_q.power;
    assign arrayHvOn = ctrl_q.power;

    // Pulse length for the selected operation
    always_comb begin
        case (mode)
            epe_pkg::MODE_PROGRAM: pulseTarget = BYTE_PROGRAM_CYCLES;
            epe_pkg::MODE_BYTE_ERASE: pulseTarget = BYTE_ERASE_CYCLES;
            epe_pkg::MODE_BLOCK_ERASE: pulseTarget = BLOCK_ERASE_CYCLES;
            epe_pkg::MODE_BULK_ERASE: pulseTarget = BULK_ERASE_CYCLES;
            default: pulseTarget = BYTE_PROGRAM_CYCLES;
        endcase
    end

    // Operation completes on the tick that ends the pulse
    assign commit = state_q == epe_pkg::ST_PULSE && ctrl_q.power && ctrl_q.capture
        && arrayTick && pulseCnt_q >= pulseTarget - epe_pkg::CNT_ONE;

    // Sequencer: capture, power pulse, one commit per pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= epe_pkg::ST_IDLE;
        end else begin
            case (state_q)
                epe_pkg::ST_IDLE: begin
                    if (ctrl_q.capture && wrArray) begin
                        state_q <= epe_pkg::ST_ARMED;
                    end
                end
                epe_pkg::ST_ARMED: begin
                    if (!ctrl_q.capture) begin
                        state_q <= epe_pkg::ST_IDLE;
                    end else if (ctrl_q.power) begin
                        state_q <= epe_pkg::ST_PULSE;
                    end
                end
                epe_pkg::ST_PULSE: begin
                    if (!ctrl_q.capture) begin
                        state_q <= epe_pkg::ST_IDLE;
                    end else if (!ctrl_q.power) begin
                        state_q <= epe_pkg::ST_ARMED;
                    end else if (commit) begin
                        state_q <= epe_pkg::ST_DONE;
                    end
                end
                epe_pkg::ST_DONE: begin
                    if (!ctrl_q.capture) begin
                        state_q <= epe_pkg::ST_IDLE;
                    end
                end
                default: state_q <= epe_pkg::ST_IDLE;
            endcase
        end
    end

    // Latch target; a later write before the pulse replaces it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_q <= '0;
        end else if (ctrl_q.capture && wrArray && state_q != epe_pkg::ST_PULSE) begin
            cap_q.addr <= busAddr[7:0];
            cap_q.data <= busWdata;
        end
    end

    // Pulse counter in array ticks; aborted pulses restart from zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulseCnt_q <= epe_pkg::CNT_ZERO;
        end else if (state_q != epe_pkg::ST_PULSE) begin
            pulseCnt_q <= epe_pkg::CNT_ZERO;
        end else if (arrayTick && pulseCnt_q != pulseTarget) begin
            pulseCnt_q <= pulseCnt_q + epe_pkg::CNT_ONE;
        end
    end

    // Oscillator settling, counted in RC edges after select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settleCnt_q <= epe_pkg::CNT_ZERO;
        end else if (!ctrl_q.oscSel) begin
            settleCnt_q <= epe_pkg::CNT_ZERO;
        end else if (rcEdge && settleCnt_q != OSC_SETTLE_CYCLES) begin
            settleCnt_q <= settleCnt_q + epe_pkg::CNT_ONE;
        end
    end
    assign oscReady = !ctrl_q.oscSel || settleCnt_q == OSC_SETTLE_CYCLES;

    // Voltage fall after power drops; only advisory for software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallCnt_q <= VOLTAGE_FALL_CYCLES;
        end else if (ctrl_q.power) begin
            fallCnt_q <= epe_pkg::CNT_ZERO;
        end else if (arrayTick && fallCnt_q != VOLTAGE_FALL_CYCLES) begin
            fallCnt_q <= fallCnt_q + epe_pkg::CNT_ONE;
        end
    end
    assign fallen = fallCnt_q == VOLTAGE_FALL_CYCLES;

    // Array cells: nonvolatile, so no reset; bits only fall on program
    always_ff @(posedge clk) begin
        if (commit) begin
            for (int i = 0; i < epe_pkg::NVM_DEPTH; i++) begin
                case (mode)
                    epe_pkg::MODE_PROGRAM: begin
                        if (8'(i) == cap_q.addr) begin
                            mem[i] <= mem[i] & cap_q.data;
                        end
                    end
                    epe_pkg::MODE_BYTE_ERASE: begin
                        if (8'(i) == cap_q.addr) begin
                            mem[i] <= epe_pkg::ERASED_BYTE;
                        end
                    end
                    epe_pkg::MODE_BLOCK_ERASE: begin
                        if (2'(i >> 6) == cap_q.addr[7:6]) begin
                            mem[i] <= epe_pkg::ERASED_BYTE;
                        end
                    end
                    default: mem[i] <= epe_pkg::ERASED_BYTE;
                endcase
            end
        end
    end

    // Register images
    assign ctrlByte = {1'b0, ctrl_q.pump, 1'b0, ctrl_q.erHigh, ctrl_q.erLow,
        ctrl_q.capture, ctrl_q.oscSel, ctrl_q.power};
    assign statusByte = {3'h0, fallen, oscReady, state_q == epe_pkg::ST_DONE,
        state_q == epe_pkg::ST_PULSE, armed};

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= epe_pkg::ZERO_BYTE;
            unreliable_q <= 1'b0;
        end else begin
            unreliable_q <= 1'b0;
            if (busRd) begin
                if (rdArray && readBlocked) begin
                    rdata_q <= epe_pkg::BLOCKED_READ;
                end else if (rdArray) begin
                    rdata_q <= mem[busAddr[7:0]];
                    unreliable_q <= busRdIndexed && baseInArray;
                end else if (busAddr == epe_pkg::CTRL_ADDR) begin
                    rdata_q <= ctrlByte;
                end else if (busAddr == epe_pkg::STAT_ADDR) begin
                    rdata_q <= statusByte;
                end else begin
                    rdata_q <= epe_pkg::ZERO_BYTE;
                end
            end
        end
    end
    assign busRdata = rdata_q;
    assign busRdUnreliable = unreliable_q;

    // Checks
    sequence sCtrlWrite;
        wrCtrl;
    endsequence

    sequence sCommitMode(epe_pkg::epe_mode_t m);
        commit && mode == m;
    endsequence

    AST_POWER_NEEDS_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
        sCtrlWrite ##0 (busWdata[epe_pkg::BIT_POWER] && !ctrl_q.capture && !ctrl_q.power)
        |=> !ctrl_q.power)
        else $error("power bit set without capture");

    // Readback after one idle cycle; bit 5 always reads zero, so it is left out
    AST_CTRL_READBACK: assert property (@(posedge clk) disable iff (!rst_n)
        sCtrlWrite ##1 !busWr ##1 (busRd && busAddr == epe_pkg::CTRL_ADDR && !busWr)
        |=> busRdata[epe_pkg::BIT_PUMP] == $past(busWdata[epe_pkg::BIT_PUMP], 3)
        && busRdata[epe_pkg::BIT_ER_HIGH:epe_pkg::BIT_OSC]
        == $past(busWdata[epe_pkg::BIT_ER_HIGH:epe_pkg::BIT_OSC], 3))
        else $error("control readback mismatch");

    AST_HV_NEEDS_POWER: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_q.pump && !ctrl_q.power) |-> (!arrayHvOn && pumpOn))
        else $error("high voltage without power bit");

    AST_READ_BLOCKED: assert property (@(posedge clk) disable iff (!rst_n)
        (rdArray && ctrl_q.capture && armed) |=> busRdata == epe_pkg::BLOCKED_READ)
        else $error("array read not blocked");

    AST_CAPTURE_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
        (wrArray && ctrl_q.capture && state_q == epe_pkg::ST_IDLE)
        |=> state_q == epe_pkg::ST_ARMED && cap_q.addr == $past(busAddr[7:0])
        && cap_q.data == $past(busWdata))
        else $error("array write not captured");

    AST_NO_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == epe_pkg::ST_IDLE && !ctrl_q.capture) |=> state_q == epe_pkg::ST_IDLE)
        else $error("armed without capture");

    AST_PROGRAM_ANDS: assert property (@(posedge clk) disable iff (!rst_n)
        sCommitMode(epe_pkg::MODE_PROGRAM) |=> mem[$past(cap_q.addr)]
        == ($past(mem[cap_q.addr]) & $past(cap_q.data)))
        else $error("program result wrong");

    AST_BYTE_ERASE: assert property (@(posedge clk) disable iff (!rst_n)
        sCommitMode(epe_pkg::MODE_BYTE_ERASE)
        |=> mem[$past(cap_q.addr)] == epe_pkg::ERASED_BYTE)
        else $error("byte erase failed");

    AST_BLOCK_ERASE: assert property (@(posedge clk) disable iff (!rst_n)
        sCommitMode(epe_pkg::MODE_BLOCK_ERASE)
        |=> mem[{$past(cap_q.addr[7:6]), epe_pkg::BLOCK_FIRST}] == epe_pkg::ERASED_BYTE
        && mem[{$past(cap_q.addr[7:6]), epe_pkg::BLOCK_LAST}] == epe_pkg::ERASED_BYTE)
        else $error("block erase failed");

    AST_BULK_ERASE: assert property (@(posedge clk) disable iff (!rst_n)
        sCommitMode(epe_pkg::MODE_BULK_ERASE)
        |=> mem[0] == epe_pkg::ERASED_BYTE && mem[epe_pkg::NVM_DEPTH - 1] == epe_pkg::ERASED_BYTE)
        else $error("bulk erase failed");

    AST_PULSE_LENGTH: assert property (@(posedge clk) disable iff (!rst_n)
        commit |-> pulseCnt_q == pulseTarget - epe_pkg::CNT_ONE && $past(ctrl_q.power))
        else $error("pulse ended at wrong count");

    AST_CPU_TIMEBASE: assert property (@(posedge clk) disable iff (!rst_n)
        (!ctrl_q.oscSel && state_q == epe_pkg::ST_PULSE && ctrl_q.power && !commit)
        |=> pulseCnt_q == $past(pulseCnt_q) + epe_pkg::CNT_ONE || state_q != epe_pkg::ST_PULSE)
        else $error("CPU clock timebase not counting");
endmodule : epe_nvm_control

//--- testbench/epe_rc_osc_model.sv
// Stand-in for the on-chip RC oscillator feeding the array timebase
`timescale 1ns/1ns
module epe_rc_osc_model #(
    parameter int HALF_NS = 70
) (
    input wire logic run,
    output logic tick
);
    // Half period not a multiple of the bus clock, but the 140 ns period is seven bus clocks, so phase repeats
    initial begin
        tick = 1'b0;
        forever begin
            #HALF_NS;
            tick = run ? ~tick : 1'b0; // Parked low when stopped, no stray edges
        end
    end
endmodule : epe_rc_osc_model

//--- testbench/tb_top.sv
// Self-checking bench for the EEPROM program/erase control block
`timescale 1ns/1ns
module tb_top;
    localparam logic [15:0] T = 16'h0004;
    localparam logic [15:0] CTRL = epe_pkg::CTRL_ADDR;
    localparam logic [15:0] STAT = epe_pkg::STAT_ADDR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] busAddr = 16'h0000;
    logic [7:0] busWdata = 8'h00;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic busRdIndexed = 1'b0;
    logic [15:0] busRdBase = 16'h0000;
    logic [7:0] busRdata;
    logic busRdUnreliable;
    logic rcOscTick;
    logic oscRun = 1'b0;
    logic pumpOn;
    logic arrayHvOn;
    logic [7:0] mem [256];
    logic [7:0] v;
    logic [7:0] a;
    logic [7:0] prevA;
    logic f;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;

    // Short counts keep every pulse and fall wait to a few ticks
    epe_nvm_control #(.BYTE_PROGRAM_CYCLES(T), .BYTE_ERASE_CYCLES(T),
        .BLOCK_ERASE_CYCLES(T), .BULK_ERASE_CYCLES(T),
        .OSC_SETTLE_CYCLES(T), .VOLTAGE_FALL_CYCLES(T)) dut (
        .clk(clk), .rst_n(rst_n), .busAddr(busAddr), .busWdata(busWdata),
        .busWr(busWr), .busRd(busRd), .busRdIndexed(busRdIndexed),
        .busRdBase(busRdBase), .busRdata(busRdata),
        .busRdUnreliable(busRdUnreliable), .rcOscTick(rcOscTick),
        .pumpOn(pumpOn), .arrayHvOn(arrayHvOn));

    epe_rc_osc_model osc (.run(oscRun), .tick(rcOscTick));

    // 50 MHz bus clock
    always #10 clk = ~clk;

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle write strobe, launched just after an edge
    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge clk);
        busWr <= 1'b1;
        busAddr <= ad;
        busWdata <= d;
        @(posedge clk);
        busWr <= 1'b0;
    endtask : wr

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [15:0] ad, input logic [15:0] base, input logic ix,
        output logic [7:0] d, output logic fl);
        @(posedge clk);
        busRd <= 1'b1;
        busAddr <= ad;
        busRdIndexed <= ix;
        busRdBase <= base;
        @(posedge clk);
        busRd <= 1'b0;
        busRdIndexed <= 1'b0;
        #1;
        d = busRdata;
        fl = busRdUnreliable;
    endtask : rd

    task automatic rdc(input logic [15:0] ad, input logic [7:0] exp);
        logic [7:0] d;
        logic fl;
        rd(ad, 16'h0000, 1'b0, d, fl);
        check(d, exp);
    endtask : rdc

    // Bounded poll of one status bit
    task automatic poll(input int b);
        logic [7:0] d;
        logic fl;
        for (int n = 0; n < 300; n++) begin
            rd(STAT, 16'h0000, 1'b0, d, fl);
            if (d[b] === 1'b1) break;
        end
        check({7'h00, d[b]}, 8'h01);
    endtask : poll

    task automatic check_all;
        for (int i = 0; i < 256; i++) begin
            rdc({8'h04, i[7:0]}, mem[i]);
        end
    endtask : check_all

    // Expected byte after one operation, from the erase-select encoding
    function automatic logic [7:0] exp_byte(input logic [1:0] m, input logic [7:0] ad,
        input logic [7:0] d, input logic [7:0] idx, input logic [7:0] old);
        case (m)
            2'h0: return (idx == ad) ? (old & d) : old;
            2'h1: return (idx == ad) ? 8'hff : old;
            2'h2: return (idx[7:6] == ad[7:6]) ? 8'hff : old;
            default: return 8'hff;
        endcase
    endfunction : exp_byte

    // Full software sequence for one program or erase, then model update
    task automatic run_op(input logic [1:0] mode, input logic [7:0] ad, input logic [7:0] d,
        input logic osc);
        logic [7:0] c;
        logic [7:0] r;
        logic fl;
        c = {1'b0, 1'b1, 1'b0, mode, 1'b1, osc, 1'b0};
        if (osc) begin
            oscRun <= 1'b1;
            wr(CTRL, 8'h02);
            poll(epe_pkg::ST_BIT_OSC_READY);
        end
        wr(CTRL, c);
        wr({8'h04, ad}, d);
        rd({8'h04, ad}, 16'h0000, 1'b0, r, fl);
        check(r, epe_pkg::BLOCKED_READ);
        if (osc) begin
            oscRun <= 1'b0;
        end
        wr(CTRL, c | 8'h01);
        #1;
        check({7'h00, arrayHvOn}, 8'h01);
        check({7'h00, pumpOn}, 8'h01);
        if (osc) begin
            // Timebase stopped: the pulse must not finish on bus clocks
            repeat (40) @(posedge clk);
            rd(STAT, 16'h0000, 1'b0, r, fl);
            check({7'h00, r[epe_pkg::ST_BIT_DONE]}, 8'h00);
            oscRun <= 1'b1;
        end
        poll(epe_pkg::ST_BIT_DONE);
        wr(CTRL, c);
        #1;
        check({7'h00, arrayHvOn}, 8'h00);
        poll(epe_pkg::ST_BIT_FALLEN);
        wr(CTRL, 8'h00);
        oscRun <= 1'b0;
        for (int j = 0; j < 256; j++) begin
            mem[j] = exp_byte(mode, ad, d, j[7:0], mem[j]);
        end
    endtask : run_op

    initial begin
        void'($urandom(6383));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Register and outputs after reset
        rdc(CTRL, 8'h00);
        check({6'h00, pumpOn, arrayHvOn}, 8'h00);
        // Pump alone never reaches the array
        wr(CTRL, 8'h40);
        #1;
        check({6'h00, pumpOn, arrayHvOn}, 8'h02);
        wr(CTRL, 8'h41);
        rdc(CTRL, 8'h40);
        wr(CTRL, 8'h45);
        rdc(CTRL, 8'h44);
        wr(CTRL, 8'h5e);
        rdc(CTRL, 8'h5e);
        // Reset in mid-run must clear every control bit, pump included
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(CTRL, 8'h00);
        check({6'h00, pumpOn, arrayHvOn}, 8'h00);
        wr(CTRL, 8'h00);
        // Contents are unknown at power-up, so start with a bulk erase
        run_op(2'h3, 8'($urandom), 8'($urandom), 1'b0);
        check_all();
        // Array write with capture clear is ignored
        wr(16'h0410, 8'h00);
        rdc(16'h0410, 8'hff);
        // Programs (one byte twice), then each erase mode, two via RC ticks
        for (int k = 0; k < 9; k++) begin
            a = 8'($urandom);
            if (k == 1) begin
                a = prevA;
            end
            prevA = a;
            run_op((k < 6) ? 2'h0 : 2'(k - 5), a, 8'($urandom), k == 2 || k == 7);
            check_all();
        end
        // Indexed read hazard flag, inside and outside the array range
        rd(16'h0405, 16'h0400, 1'b1, v, f);
        check({7'h00, f}, 8'h01);
        check(v, mem[5]);
        rd(16'h0405, 16'h0300, 1'b1, v, f);
        check({7'h00, f}, 8'h00);
        check(v, mem[5]);
        // Just outside the array and an unused register slot
        rdc(16'h03ff, 8'h00);
        rdc(16'h0500, 8'h00);
        rdc(16'h001e, 8'h00);
        tally_and_finish();
    end
endmodule : tb_top
